// ==== tb/ddli_dev_model.sv ====
`timescale 1ns/1ns
`include "ddli_map.svh"
module ddli_dev import ddli_pkg::*; (
  input wire logic clk_i,
  input wire ddli_pins_s pins_i,
  output logic [11:0] dac_a_o = 12'h000,
  output logic [11:0] dac_b_o = 12'h000
);
  // The real latches are transparent; sampling the registered pins on the clock gives the same contents.
  logic [11:0] in_a = 12'h000;
  logic [11:0] in_b = 12'h000;
  logic wr_prev = 1'b1;
  always @(posedge clk_i) begin
    wr_prev <= pins_i.write_strobe_n;
    // Word mode: the rising write edge loads the selected DAC latches directly.
    if (!wr_prev && pins_i.write_strobe_n) begin
      if (!pins_i.channel_a_select_n) dac_a_o <= {pins_i.data_msb_pin, pins_i.data_bits_rest};
      if (!pins_i.channel_b_select_n) dac_b_o <= {pins_i.data_msb_pin, pins_i.data_bits_rest};
    end
    if (!pins_i.device_select_n && !pins_i.write_strobe_n) begin
      case ({pins_i.addr_hi_sel, pins_i.addr_lo_sel})
        `DDLI_SEL_A_LO: in_a[7:0] <= pins_i.data_bits_rest[7:0];
        `DDLI_SEL_A_HI: in_a[11:8] <= pins_i.data_bits_rest[3:0];
        `DDLI_SEL_B_LO: in_b[7:0] <= pins_i.data_bits_rest[7:0];
        default: in_b[11:8] <= pins_i.data_bits_rest[3:0];
      endcase
    end
    if (!pins_i.dac_update_n) begin
      dac_a_o <= in_a;
      dac_b_o <= in_b;
    end
  end
endmodule : ddli_dev

// ==== tb/ddli_host_assertions.sv ====
`timescale 1ns/1ns
module ddli_host_chk import ddli_pkg::*; (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire ddli_req_s req_i,
  input wire logic req_valid_i,
  input wire logic req_ready_o,
  input wire ddli_pins_s pins_o
);
  ddli_pins_s p;
  assign p = pins_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_wr;
    $fell(p.write_strobe_n) && !p.device_select_n;
  endsequence
  a_write_width: assert property (s_wr |-> !p.write_strobe_n[*3] ##1 p.write_strobe_n)
    else $error("write pulse width");
  a_idle_quiet: assert property (req_ready_o |-> p.device_select_n && p.dac_update_n)
    else $error("idle pins active");
  a_data_steady: assert property (!p.write_strobe_n |-> $stable(p.data_bits_rest))
    else $error("data moved in write");
  a_chan_a_only: assert property (!p.channel_a_select_n |-> p.device_select_n)
    else $error("select clash a");
  a_chan_b_only: assert property (!p.channel_b_select_n |-> p.device_select_n)
    else $error("select clash b");
  a_upper_zero: assert property (!p.device_select_n |-> !p.data_msb_pin && p.data_bits_rest[10:8] == 3'h0)
    else $error("upper data bits set");
  a_update_width: assert property ($fell(p.dac_update_n) |-> !p.dac_update_n[*3] ##1 p.dac_update_n)
    else $error("update pulse width");
  a_update_apart: assert property (!p.dac_update_n |-> p.device_select_n && p.write_strobe_n)
    else $error("update overlaps write");
  a_sel_hold: assert property ($rose(p.write_strobe_n) |->
    $stable(p.channel_a_select_n) && $stable(p.channel_b_select_n) && $stable(p.device_select_n))
    else $error("select moved at write edge");
endmodule : ddli_host_chk
bind ddli_host ddli_host_chk u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i),
  .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .pins_o(pins_o));

// ==== tb/dual_dac_latch_interface_tb_top.sv ====
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; $display("CHECK FAILED %0t value", $time); end end
module dual_dac_latch_interface_tb_top;
  import ddli_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic req_valid_i = 1'b0;
  ddli_req_s req_i = '0;
  logic req_ready_o;
  ddli_pins_s pins_o;
  logic ready_w;
  ddli_pins_s pins_w;
  logic [11:0] dac_wa, dac_wb;
  logic [11:0] dac_a, dac_b, exp_a = 12'h000, exp_b = 12'h000;
  logic [31:0] r;
  int n_mismatch = 0, n_tests = 0, cyc = 0, seed = 32'hd6d6;
  ddli_host dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .pins_o(pins_o));
  ddli_dev u_dev (.clk_i(clk_i), .pins_i(pins_o), .dac_a_o(dac_a), .dac_b_o(dac_b));
  ddli_host #(.BYTE_MODE(1'b0)) dut_w (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i),
    .req_valid_i(req_valid_i), .req_ready_o(ready_w), .pins_o(pins_w));
  ddli_dev u_dev_w (.clk_i(clk_i), .pins_i(pins_w), .dac_a_o(dac_wa), .dac_b_o(dac_wb));
  function automatic logic [11:0] pick(input logic [11:0] old, input logic [11:0] w, input logic en);
    return en ? w : old;
  endfunction : pick
  initial forever #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_mismatch++;
      conclude();
    end
  end
  task send(input logic [11:0] w, input logic a, input logic b);
    int k;
    req_i = '{w, a, b};
    req_valid_i = 1'b1;
    @(negedge clk_i);
    req_valid_i = 1'b0;
    for (k = 0; k < 100 && (req_ready_o !== 1'b1 || ready_w !== 1'b1); k++) @(negedge clk_i);
    exp_a = pick(exp_a, w, a);
    exp_b = pick(exp_b, w, b);
    `CHK(req_ready_o, 1'b1)
    `CHK(ready_w, 1'b1)
    `CHK(dac_a, exp_a)
    `CHK(dac_b, exp_b)
    `CHK(dac_wa, exp_a)
    `CHK(dac_wb, exp_b)
  endtask : send
  task conclude;
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (2) @(negedge clk_i);
    sys_rst_i = 1'b0;
    send(12'hfff, 1'b1, 1'b1);
    send(12'h000, 1'b1, 1'b0);
    send(12'h800, 1'b0, 1'b1);
    send(12'h7ff, 1'b0, 1'b0);
    repeat (40) begin
      r = $random(seed);
      send(r[11:0], r[12], r[13]);
    end
    conclude();
  end
endmodule : dual_dac_latch_interface_tb_top

// ==== verilog/ddli_host.sv ====
`timescale 1ns/1ns
`include "ddli_map.svh"
// Operation
// - Byte mode writes only with device select low.
// - Write needs strobe and select low together.
// - Byte lanes: low half word[7:0], high word[11:8].
// - Channel A select low only loads A.
// - Channel B select low only loads B.
// - Word mode sends twelve bits in one write.
// - Byte mode: update stays low one pulse width after the last write; word mode gives no update pulse.
module ddli_host import ddli_pkg::*; #(
  parameter bit BYTE_MODE = 1'b1
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire ddli_req_s req_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  output ddli_pins_s pins_o
);
  // A pulse never shrinks below one clock, even when a figure is set below the clock period.
  localparam int UPD_CYC = (`DDLI_CYC(`DDLI_UPDATE_PW_NS) < 1) ? 1 : `DDLI_CYC(`DDLI_UPDATE_PW_NS);
  localparam int WR_CYC = (`DDLI_CYC(`DDLI_WRITE_PW_NS) < 1) ? 1 : `DDLI_CYC(`DDLI_WRITE_PW_NS);
  localparam int SU_CYC = (`DDLI_CYC(`DDLI_SETUP_NS) < 1) ? 1 : `DDLI_CYC(`DDLI_SETUP_NS);
  localparam int CNT_MAX = 15;

  // Counts beyond the 4-bit counter would wrap and cut a pulse short, so such settings are refused.
  if (UPD_CYC > CNT_MAX) begin : g_upd_chk
    $error("ddli_host: update pulse count exceeds the counter.");
  end
  if (WR_CYC > CNT_MAX) begin : g_wr_chk
    $error("ddli_host: write pulse count exceeds the counter.");
  end
  if (SU_CYC > CNT_MAX) begin : g_su_chk
    $error("ddli_host: setup count exceeds the counter.");
  end

  // The counter holds the cycles left after the current one in the current timed phase.
  ddli_state_e state_reg;
  ddli_state_e state_next;
  ddli_req_s req_reg;
  logic [1:0] step_reg;
  logic [1:0] step_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  ddli_pins_s pins_reg;
  ddli_pins_s pins_next;

  // Step order in byte mode: A lo, A hi, B lo, B hi, skipping unselected channels.
  wire logic step_wanted = step_reg[1] ? req_reg.ch_b : req_reg.ch_a;
  wire logic [1:0] sel_code = step_reg;
  wire logic [7:0] byte_lane = step_reg[0] ? {4'h0, req_reg.word[11:8]} : req_reg.word[7:0];
  wire logic [3:0] cnt_dec = cnt_reg - 4'h1;
  wire logic cnt_done = (cnt_reg == 4'h0);
  wire logic word_mode = !BYTE_MODE;
  wire logic last_step = (step_reg == `DDLI_SEL_B_HI);
  wire logic [1:0] step_inc = step_reg + 2'h1;
  wire logic [1:0] first_step = req_i.ch_a ? `DDLI_SEL_A_LO : `DDLI_SEL_B_LO;
  wire logic req_take = req_valid_i && req_ready_o;
  // Ready comes from the state register alone, so it never loops back through req_valid_i.
  assign req_ready_o = (state_reg == DDLI_IDLE);
  assign pins_o = pins_reg;

  // Byte mode walks NEXT, SETUP, STROBE and HOLD once per wanted half, then gives one UPDATE pulse.
  // Word mode goes from IDLE straight to SETUP, since one write carries the whole word.
  always_comb begin
    state_next = state_reg;
    step_next = step_reg;
    cnt_next = cnt_done ? 4'h0 : cnt_dec;
    pins_next = pins_reg;
    case (state_reg)
      DDLI_IDLE: begin
        // Every strobe and select stays high between transfers.
        pins_next.device_select_n = 1'b1;
        pins_next.channel_a_select_n = 1'b1;
        pins_next.channel_b_select_n = 1'b1;
        pins_next.write_strobe_n = 1'b1;
        pins_next.dac_update_n = 1'b1;
        if (req_valid_i) begin
          state_next = DDLI_NEXT;
          step_next = first_step;
          if (word_mode) begin
            // Data and channel selects go out now; the write strobe follows after the setup count.
            state_next = DDLI_SETUP;
            cnt_next = 4'(SU_CYC - 1);
            pins_next.data_msb_pin = req_i.word[11];
            pins_next.data_bits_rest = req_i.word[10:0];
            pins_next.channel_a_select_n = ~req_i.ch_a;
            pins_next.channel_b_select_n = ~req_i.ch_b;
          end
        end
      end

      DDLI_NEXT: begin
        // An unwanted B half costs one cycle and no bus activity; unwanted A halves are never visited.
        if (step_wanted) begin
          state_next = DDLI_SETUP;
          cnt_next = 4'(SU_CYC - 1);
          pins_next.addr_hi_sel = sel_code[1];
          pins_next.addr_lo_sel = sel_code[0];
          pins_next.data_bits_rest = {3'h0, byte_lane};
          pins_next.data_msb_pin = 1'b0;
          pins_next.device_select_n = 1'b0;
        end else if (last_step) begin
          state_next = DDLI_UPDATE;
          cnt_next = 4'(UPD_CYC - 1);
          pins_next.dac_update_n = 1'b0;
        end else begin
          step_next = step_inc;
        end
      end

      DDLI_SETUP: begin
        // Address and data settle for the setup count before the write strobe falls.
        if (cnt_done) begin
          state_next = DDLI_STROBE;
          cnt_next = 4'(WR_CYC - 1);
          pins_next.write_strobe_n = 1'b0;
        end
      end

      DDLI_STROBE: begin
        // In byte mode the chosen input latch stays transparent for the whole pulse.
        if (cnt_done) begin
          // Rising write edge latches the word in word mode.
          state_next = DDLI_HOLD;
          pins_next.write_strobe_n = 1'b1;
        end
      end

      DDLI_HOLD: begin
        // Selects drop one cycle after the write edge so address and data hold time is met.
        pins_next.device_select_n = 1'b1;
        pins_next.channel_a_select_n = 1'b1;
        pins_next.channel_b_select_n = 1'b1;
        if (word_mode) begin
          state_next = DDLI_IDLE;
        end else if (last_step) begin
          // The update pulse starts only after the write ends, so no overlap can occur.
          state_next = DDLI_UPDATE;
          cnt_next = 4'(UPD_CYC - 1);
          pins_next.dac_update_n = 1'b0;
        end else begin
          state_next = DDLI_NEXT;
          step_next = step_inc;
        end
      end

      DDLI_UPDATE: begin
        // Both DAC latches follow their input latches for the whole pulse.
        if (cnt_done) begin
          state_next = DDLI_IDLE;
          pins_next.dac_update_n = 1'b1;
        end
      end

      default: begin
        state_next = DDLI_IDLE;
      end
    endcase
  end

  // Each register keeps its reset value beside its update.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= DDLI_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      step_reg <= `DDLI_RST_STEP;
    end else begin
      step_reg <= step_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_reg <= `DDLI_RST_CNT;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Copying the whole request at the take lets the caller change req_i while a transfer runs.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      req_reg <= '0;
    end else if (req_take) begin
      req_reg <= req_i;
    end
  end

  // The pins reset to the idle level, with every strobe and select inactive.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pins_reg.device_select_n <= `DDLI_RST_STROBE;
      pins_reg.channel_a_select_n <= `DDLI_RST_STROBE;
      pins_reg.channel_b_select_n <= `DDLI_RST_STROBE;
      pins_reg.write_strobe_n <= `DDLI_RST_STROBE;
      pins_reg.dac_update_n <= `DDLI_RST_STROBE;
      pins_reg.addr_hi_sel <= `DDLI_RST_ADDR;
      pins_reg.addr_lo_sel <= `DDLI_RST_ADDR;
      pins_reg.data_msb_pin <= `DDLI_RST_MSB;
      pins_reg.data_bits_rest <= `DDLI_RST_DATA;
    end else begin
      pins_reg <= pins_next;
    end
  end
endmodule : ddli_host

// ==== verilog/ddli_map.svh ====
`ifndef DDLI_MAP_SVH
`define DDLI_MAP_SVH
// Byte-wide latch-select codes.
`define DDLI_SEL_A_LO 2'h0
`define DDLI_SEL_A_HI 2'h1
`define DDLI_SEL_B_LO 2'h2
`define DDLI_SEL_B_HI 2'h3
// Bus timing figures in ns; the write and update pulse widths are plain defaults.
`define DDLI_CLK_NS 20
`define DDLI_UPDATE_PW_NS 50
`define DDLI_WRITE_PW_NS 50
`define DDLI_SETUP_NS 20
// Reset values: every active-low strobe and select rests inactive, address and data at zero.
`define DDLI_RST_STEP 2'h0
`define DDLI_RST_CNT 4'h0
`define DDLI_RST_STROBE 1'b1
`define DDLI_RST_ADDR 1'b0
`define DDLI_RST_MSB 1'b0
`define DDLI_RST_DATA 11'h000
// Least times round up to whole clock cycles.
`define DDLI_CYC(ns) (((ns) + `DDLI_CLK_NS - 1) / `DDLI_CLK_NS)
`endif

// ==== verilog/ddli_pkg.sv ====
package ddli_pkg;
  typedef struct packed {
    logic [11:0] word;
    logic ch_a;
    logic ch_b;
  } ddli_req_s;
  typedef struct packed {
    logic device_select_n;
    logic channel_a_select_n;
    logic channel_b_select_n;
    logic write_strobe_n;
    logic dac_update_n;
    logic addr_hi_sel;
    logic addr_lo_sel;
    logic data_msb_pin;
    logic [10:0] data_bits_rest;
  } ddli_pins_s;
  typedef enum logic [2:0] {
    DDLI_IDLE, DDLI_SETUP, DDLI_STROBE, DDLI_HOLD, DDLI_NEXT, DDLI_UPDATE
  } ddli_state_e;
endpackage : ddli_pkg
